// ==== hpsc_top.sv ====
// hub power budget and string configuration register bank
`timescale 1ns/100ps
`default_nettype none
module hpsc_top
    import hpsc_pkg::*;
(
    input wire logic i_clk,                   // 10 MHz core clock
    input wire logic i_nrst,                  // async reset, low
    input wire logic i_wr_en,                 // loader write strobe
    input wire logic i_rd_en,                 // loader read strobe
    input wire hpsc_pkg::hpsc_addr_t i_addr,  // register offset
    input wire hpsc_pkg::hpsc_byte_t i_wdata, // write data
    output hpsc_pkg::hpsc_byte_t o_rdata,     // read data, registered
    output var logic o_rvalid,                // read data valid pulse
    input wire logic i_self_powered,          // powering mode, same domain
    input wire logic i_string_en,             // string support enable
    output hpsc_pkg::hpsc_byte_t o_max_power,     // budget for descriptor
    output hpsc_pkg::hpsc_byte_t o_ctrl_current,  // own draw for descriptor
    output hpsc_pkg::hpsc_byte_t o_settle_time,   // port power-on delay
    output hpsc_pkg::hpsc_lang_t o_lang_code,     // language code
    output hpsc_pkg::hpsc_byte_t o_maker_len,     // maker string length
    output var logic o_strings_on                 // string support active
);
    `include "hpsc_consts.svh"

    hpsc_byte_t regs_r [`HPSC_NUM_REGS];
    hpsc_byte_t regs_nxt [`HPSC_NUM_REGS];
    hpsc_byte_t rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    hpsc_cfg_if cfg ();

    // map an offset to a slot index; out of range gives -1
    function automatic int slot_of(input hpsc_addr_t a);
        if (a >= `HPSC_OFS_MAX_POWER_SELF && a <= `HPSC_OFS_MAKER_STR_LEN)
            return int'(a - `HPSC_OFS_MAX_POWER_SELF);
        return -1;
    endfunction

    // write path; every slot plain 8-bit storage, loader keeps ranges
    always_comb begin
        for (int k = 0; k < `HPSC_NUM_REGS; k++) begin
            regs_nxt[k] = regs_r[k];
        end
        if (i_wr_en && slot_of(i_addr) >= 0) begin
            regs_nxt[slot_of(i_addr)] = i_wdata;
        end
    end

    // storage; controller draw defaults to 100 mA
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int k = 0; k < `HPSC_NUM_REGS; k++) begin
                regs_r[k] <= `HPSC_RST_ZERO;
            end
            regs_r[2] <= `HPSC_RST_CTRL_CURRENT;
            regs_r[3] <= `HPSC_RST_CTRL_CURRENT;
        end else begin
            for (int k = 0; k < `HPSC_NUM_REGS; k++) begin
                regs_r[k] <= regs_nxt[k];
            end
        end
    end

    // read path; unmapped offsets answer zero, same one-cycle timing
    always_comb begin
        rvalid_nxt = i_rd_en;
        rdata_nxt = rdata_r;
        if (i_rd_en) begin
            if (slot_of(i_addr) >= 0) begin
                rdata_nxt = regs_r[slot_of(i_addr)];
            end else begin
                rdata_nxt = `HPSC_RDATA_UNMAPPED;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_r <= `HPSC_RST_ZERO;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // fan stored slots onto the interface
    assign cfg.max_power_self = regs_r[0];
    assign cfg.max_power_bus = regs_r[1];
    assign cfg.ctrl_current_self = regs_r[2];
    assign cfg.ctrl_current_bus = regs_r[3];
    assign cfg.settle_time = regs_r[4];
    assign cfg.lang_high = regs_r[5];
    assign cfg.lang_low = regs_r[6];
    assign cfg.maker_len = regs_r[7];

    assign o_rdata = rdata_r;
    assign o_rvalid = rvalid_r;
    assign o_settle_time = regs_r[4];

    hpsc_select u_select (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_self_powered(i_self_powered),
        .i_string_en(i_string_en),
        .cfg(cfg),
        .o_max_power(o_max_power),
        .o_ctrl_current(o_ctrl_current),
        .o_lang_code(o_lang_code),
        .o_maker_len(o_maker_len),
        .o_strings_on(o_strings_on)
    );

    sequence write_self_s;
        i_wr_en && !i_rd_en && i_addr == 8'h0c;
    endsequence
    sequence write_bus_s;
        i_wr_en && !i_rd_en && i_addr == 8'h0d;
    endsequence

    wr_self_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        write_self_s |=> cfg.max_power_self == $past(i_wdata))
        else $error("self-powered budget write lost");
    wr_bus_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        write_bus_s |=> cfg.max_power_bus == $past(i_wdata))
        else $error("bus-powered budget write lost");
    rd_self_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (write_self_s ##1 (i_rd_en && i_addr == 8'h0c && !i_wr_en))
        |=> o_rvalid && o_rdata == $past(i_wdata, 2))
        else $error("readback of budget wrong");
    cur_self_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_wr_en && i_addr == 8'h0e) |=> cfg.ctrl_current_self
        == $past(i_wdata))
        else $error("self controller draw write lost");
    cur_bus_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_wr_en && i_addr == 8'h0f) |=> cfg.ctrl_current_bus
        == $past(i_wdata))
        else $error("bus controller draw write lost");
    rst_cur_a: assert property (@(posedge i_clk)
        $rose(i_nrst) |-> cfg.ctrl_current_bus == 8'h32)
        else $error("controller draw reset value wrong");
    settle_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_wr_en && i_addr == 8'h10) |=> o_settle_time == $past(i_wdata))
        else $error("settle time not reported");
    lang_low_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_wr_en && i_addr == 8'h12 && i_string_en) ##1 i_string_en
        |=> o_lang_code[7:0] == $past(i_wdata, 2))
        else $error("language low byte not reported");
    mode_bus_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (!i_self_powered && !i_wr_en) [*2] |-> o_max_power
        == cfg.max_power_bus)
        else $error("bus-powered budget not selected");
    unmap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_rd_en && i_addr > 8'h13) |=> o_rvalid && o_rdata == 8'h00)
        else $error("unmapped read not zero");

    // a write elsewhere must leave the stored slots untouched
    sequence unmapped_write_s;
        i_wr_en && (i_addr < `HPSC_OFS_MAX_POWER_SELF ||
            i_addr > `HPSC_OFS_MAKER_STR_LEN);
    endsequence
    // read and write of one offset in one cycle; read sees the old value
    sequence collide_bus_s;
        i_wr_en && i_rd_en && i_addr == `HPSC_OFS_MAX_POWER_BUS;
    endsequence
    // a read strobe of one controller draw slot
    sequence read_cur_self_s;
        i_rd_en && i_addr == `HPSC_OFS_CTRL_CURRENT_SELF;
    endsequence
    sequence read_cur_bus_s;
        i_rd_en && i_addr == `HPSC_OFS_CTRL_CURRENT_BUS;
    endsequence

    rvalid_pulse_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_rd_en |=> !o_rvalid)
        else $error("read valid without a read strobe");
    rd_cur_self_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        read_cur_self_s |=> o_rdata == $past(cfg.ctrl_current_self))
        else $error("self controller draw readback wrong");
    rd_cur_bus_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        read_cur_bus_s |=> o_rdata == $past(cfg.ctrl_current_bus))
        else $error("bus controller draw readback wrong");
    rd_settle_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_rd_en && i_addr == `HPSC_OFS_SETTLE_TIME)
        |=> o_rdata == $past(o_settle_time))
        else $error("settle time readback wrong");
    wr_lang_high_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_wr_en && i_addr == `HPSC_OFS_LANG_HIGH)
        |=> cfg.lang_high == $past(i_wdata))
        else $error("language high byte write lost");
    wr_lang_low_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_wr_en && i_addr == `HPSC_OFS_LANG_LOW)
        |=> cfg.lang_low == $past(i_wdata))
        else $error("language low byte write lost");
    wr_len_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_wr_en && i_addr == `HPSC_OFS_MAKER_STR_LEN)
        |=> cfg.maker_len == $past(i_wdata))
        else $error("string length write lost");
    unmap_keep_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        unmapped_write_s |=> $stable(cfg.max_power_self)
        && $stable(cfg.maker_len))
        else $error("unmapped write disturbed the bank");
    collide_old_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        collide_bus_s |=> o_rdata == $past(cfg.max_power_bus))
        else $error("colliding read did not return the old value");
    hold_self_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !(i_wr_en && i_addr == `HPSC_OFS_MAX_POWER_SELF)
        |=> $stable(cfg.max_power_self))
        else $error("self-powered budget changed without a write");
    rst_cur_self_a: assert property (@(posedge i_clk)
        $rose(i_nrst)
        |-> cfg.ctrl_current_self == `HPSC_RST_CTRL_CURRENT)
        else $error("self controller draw reset value wrong");
endmodule
`default_nettype wire

// ==== hpsc_consts.svh ====
// register offsets, reset values and field constants of the power/string bank
`ifndef HPSC_CONSTS_SVH
`define HPSC_CONSTS_SVH
`define HPSC_OFS_MAX_POWER_SELF 8'h0c
`define HPSC_OFS_MAX_POWER_BUS 8'h0d
`define HPSC_OFS_CTRL_CURRENT_SELF 8'h0e
`define HPSC_OFS_CTRL_CURRENT_BUS 8'h0f
`define HPSC_OFS_SETTLE_TIME 8'h10
`define HPSC_OFS_LANG_HIGH 8'h11
`define HPSC_OFS_LANG_LOW 8'h12
`define HPSC_OFS_MAKER_STR_LEN 8'h13
`define HPSC_RST_CTRL_CURRENT 8'h32
`define HPSC_RST_ZERO 8'h00
`define HPSC_RDATA_UNMAPPED 8'h00
`define HPSC_STRING_LEN_MAX 8'h1f
`define HPSC_NUM_REGS 8
`define HPSC_POWER_UNIT_MA 2
`define HPSC_SETTLE_UNIT_MS 2
`endif

// ==== hpsc_pkg.sv ====
// types shared by the power/string configuration bank
package hpsc_pkg;
    typedef logic [7:0] hpsc_byte_t;
    typedef logic [7:0] hpsc_addr_t;
    typedef logic [15:0] hpsc_lang_t;
endpackage

// ==== hpsc_cfg_if.sv ====
// interface carrying the stored register values to the descriptor mux
`timescale 1ns/100ps
`default_nettype none
interface hpsc_cfg_if;
    logic [7:0] max_power_self;
    logic [7:0] max_power_bus;
    logic [7:0] ctrl_current_self;
    logic [7:0] ctrl_current_bus;
    logic [7:0] settle_time;
    logic [7:0] lang_high;
    logic [7:0] lang_low;
    logic [7:0] maker_len;
    modport store (output max_power_self, max_power_bus, ctrl_current_self,
        ctrl_current_bus, settle_time, lang_high, lang_low, maker_len);
    modport use_side (input max_power_self, max_power_bus, ctrl_current_self,
        ctrl_current_bus, settle_time, lang_high, lang_low, maker_len);
endinterface
`default_nettype wire

// ==== hpsc_select.sv ====
// descriptor field selection from the stored configuration values
`timescale 1ns/100ps
`default_nettype none
module hpsc_select
    import hpsc_pkg::*;
(
    input wire logic i_clk,                  // core clock
    input wire logic i_nrst,                 // async reset, low
    input wire logic i_self_powered,         // powering mode, same domain
    input wire logic i_string_en,            // string support enable
    hpsc_cfg_if.use_side cfg,                // stored values
    output hpsc_pkg::hpsc_byte_t o_max_power,    // selected budget
    output hpsc_pkg::hpsc_byte_t o_ctrl_current, // selected own draw
    output hpsc_pkg::hpsc_lang_t o_lang_code,    // 16-bit language code
    output hpsc_pkg::hpsc_byte_t o_maker_len,    // string length or zero
    output var logic o_strings_on                // string support active
);
    `include "hpsc_consts.svh"
    hpsc_byte_t pwr_r, pwr_nxt, cur_r, cur_nxt, len_r, len_nxt;
    hpsc_lang_t lang_r, lang_nxt;
    logic on_r, on_nxt;

    // pick values by powering mode; strings blanked when disabled
    always_comb begin
        pwr_nxt = i_self_powered ? cfg.max_power_self : cfg.max_power_bus;
        cur_nxt = i_self_powered ? cfg.ctrl_current_self
                                 : cfg.ctrl_current_bus;
        on_nxt = i_string_en;
        lang_nxt = i_string_en ? {cfg.lang_high, cfg.lang_low}
                               : 16'h0000;
        len_nxt = i_string_en ? cfg.maker_len : `HPSC_RST_ZERO;
    end

    // registered so descriptor data is glitch free
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pwr_r <= `HPSC_RST_ZERO;
            cur_r <= `HPSC_RST_CTRL_CURRENT;
            lang_r <= 16'h0000;
            len_r <= `HPSC_RST_ZERO;
            on_r <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            cur_r <= cur_nxt;
            lang_r <= lang_nxt;
            len_r <= len_nxt;
            on_r <= on_nxt;
        end
    end

    assign o_max_power = pwr_r;
    assign o_ctrl_current = cur_r;
    assign o_lang_code = lang_r;
    assign o_maker_len = len_r;
    assign o_strings_on = on_r;

    sel_mode_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_self_powered |=> o_max_power == $past(cfg.max_power_self))
        else $error("power budget not taken from self-powered value");
    sel_lang_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_string_en |=> o_lang_code[15:8] == $past(cfg.lang_high))
        else $error("language high byte misplaced");
    sel_blank_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_string_en |=> o_maker_len == 8'h00 && !o_strings_on)
        else $error("string length shown while strings disabled");
endmodule
`default_nettype wire

// ==== hpsc_host_model.sv ====
// host-side model fetching the hub's descriptor fields
`timescale 1ns/100ps
`default_nettype none
module hpsc_host_model
    import hpsc_pkg::*;
(
    input wire logic i_clk,                  // core clock
    input wire logic i_fetch,                // descriptor request
    input wire hpsc_pkg::hpsc_byte_t i_pwr,  // reported budget
    input wire hpsc_pkg::hpsc_byte_t i_cur,  // reported own draw
    input wire hpsc_pkg::hpsc_byte_t i_set,  // reported settle time
    input wire hpsc_pkg::hpsc_lang_t i_lang, // reported language
    input wire hpsc_pkg::hpsc_byte_t i_len,  // reported string length
    output logic [47:0] o_desc               // last fetched descriptor
);
    // the host only sees the fields at the moment it asks
    always_ff @(posedge i_clk) begin
        if (i_fetch) begin
            o_desc <= {i_pwr, i_cur, i_set, i_lang, i_len};
        end
    end
endmodule
`default_nettype wire

// ==== test_hub_power_and_string_config.sv ====
// self-checking bench for the power and string configuration bank
`timescale 1ns/100ps
`default_nettype none
module test_hub_power_and_string_config;
    import hpsc_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic self_pw = 1'b1;
    logic str_en = 1'b0;
    logic fetch = 1'b0;
    hpsc_addr_t addr = 8'h00;
    hpsc_byte_t wdata = 8'h00;
    hpsc_byte_t rdata, pwr, cur, set_t, mlen;
    hpsc_lang_t lang;
    logic rvalid, str_on;
    logic [47:0] desc;
    int n_fail = 0;
    int samples_checked = 0;
    // loader values: self values at 100 mA or less, length at 31
    hpsc_byte_t v [8] = '{8'h32, 8'hfa, 8'h19, 8'h7d,
        8'h64, 8'h04, 8'h09, 8'h1f};
    always #50 clk = ~clk;
    hpsc_top dut (.i_clk(clk), .i_nrst(nrst), .i_wr_en(wr_en),
        .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .o_rvalid(rvalid), .i_self_powered(self_pw), .i_string_en(str_en),
        .o_max_power(pwr), .o_ctrl_current(cur), .o_settle_time(set_t),
        .o_lang_code(lang), .o_maker_len(mlen), .o_strings_on(str_on));
    hpsc_host_model host (.i_clk(clk), .i_fetch(fetch), .i_pwr(pwr),
        .i_cur(cur), .i_set(set_t), .i_lang(lang), .i_len(mlen),
        .o_desc(desc));
    task automatic chk(input string what, input logic [47:0] exp,
        input logic [47:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one write strobe, launched and dropped at falling edges
    task automatic wr(input hpsc_addr_t a, input hpsc_byte_t d);
        @(negedge clk);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr_en = 1'b0;
    endtask
    // read answer stands one cycle, so it is judged right then
    task automatic rd(input hpsc_addr_t a, input hpsc_byte_t exp);
        @(negedge clk);
        rd_en = 1'b1;
        addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        chk("rvalid", 48'h1, {47'h0, rvalid});
        chk("rdata", {40'h0, exp}, {40'h0, rdata});
    endtask
    // selector lags a write by two cycles, then the host fetches
    task automatic host_chk(input logic [47:0] exp);
        repeat (3) @(negedge clk);
        fetch = 1'b1;
        @(negedge clk);
        fetch = 1'b0;
        chk("descriptor", exp, desc);
    endtask
    task automatic t_reset;
        for (int i = 0; i < 8; i++) begin
            rd(8'h0c + i, (i == 2 || i == 3) ? 8'h32 : 8'h00);
        end
        host_chk({8'h00, 8'h32, 8'h00, 16'h0000, 8'h00});
        $display("test reset values done");
    endtask
    task automatic t_regs;
        for (int i = 0; i < 8; i++) begin
            wr(8'h0c + i, v[i]);
        end
        for (int i = 0; i < 8; i++) begin
            rd(8'h0c + i, v[i]);
        end
        $display("test register access done");
    endtask
    task automatic t_mode;
        str_en = 1'b1;
        self_pw = 1'b1;
        host_chk({v[0], v[2], v[4], v[5], v[6], v[7]});
        chk("strings_on", 48'h1, {47'h0, str_on});
        self_pw = 1'b0;
        host_chk({v[1], v[3], v[4], v[5], v[6], v[7]});
        $display("test powering mode done");
    endtask
    task automatic t_strings;
        str_en = 1'b0;
        host_chk({v[1], v[3], v[4], 16'h0000, 8'h00});
        chk("strings_on", 48'h0, {47'h0, str_on});
        $display("test string disable done");
    endtask
    // unmapped places neither store nor disturb the bank
    task automatic t_unmapped;
        wr(8'h14, 8'h5a);
        wr(8'h0b, 8'ha5);
        rd(8'h14, 8'h00);
        rd(8'h0b, 8'h00);
        rd(8'hff, 8'h00);
        rd(8'h13, v[7]);
        rd(8'h0c, v[0]);
        $display("test unmapped access done");
    endtask
    // write then read back to back, then both strobes on one offset
    task automatic t_b2b;
        str_en = 1'b1;
        self_pw = 1'b1;
        @(negedge clk);
        wr_en = 1'b1;
        addr = 8'h0c;
        wdata = 8'h28;
        @(negedge clk);
        wr_en = 1'b0;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        chk("rvalid", 48'h1, {47'h0, rvalid});
        chk("rdata", 48'h28, {40'h0, rdata});
        @(negedge clk);
        wr_en = 1'b1;
        rd_en = 1'b1;
        addr = 8'h0d;
        wdata = 8'h3c;
        @(negedge clk);
        wr_en = 1'b0;
        rd_en = 1'b0;
        chk("rdata old", {40'h0, v[1]}, {40'h0, rdata});
        rd(8'h0d, 8'h3c);
        wr(8'h12, 8'h0a);
        host_chk({8'h28, v[2], v[4], v[5], 8'h0a, v[7]});
        $display("test back to back done");
    endtask
    // reset again in mid-run: stored values return to their defaults
    task automatic t_rerun_reset;
        @(negedge clk);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        rd(8'h0e, 8'h32);
        rd(8'h0f, 8'h32);
        rd(8'h0c, 8'h00);
        host_chk({8'h00, 8'h32, 8'h00, 16'h0000, 8'h00});
        $display("test reset in mid-run done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #2000000;
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        t_reset();
        t_regs();
        t_mode();
        t_strings();
        t_unmapped();
        t_b2b();
        t_rerun_reset();
        wrap_up();
    end
endmodule
`default_nettype wire
